// ==== hrmoc_bench.sv ====
// Self-checking bench of the register bank and port-power control.
// Assumes hrmoc_host as processor and a short overcurrent filter.
`timescale 1ns/1ns
module hrmoc_bench
  import hrmoc_pkg::*;
;
  localparam logic [16:0] FILT = 17'h8;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  cs_n, rd_n, wr_n, oe, irq;
  logic [17:1]           addr;
  logic [31:0]           din, dout, rdat;
  logic [NCLS-1:0][31:0] done = '0;
  logic [2:0]            req = 3'h0, oc_n = 3'h7, aoc = 3'h0, pen_n;
  logic [31:0]           seed = 32'h4a41721e;
  int                    num_errors = 0, cmp_count = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  hrmoc_top #(.OC_FILTER_CYCLES(FILT)) DUT (.CLK_SYS(clk), .RESETN(rst_n),
    .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(oe), .IRQ_OUT(irq), .DONE_SET(done),
    .PORT_POWER_REQ(req), .PORT_OVERCURRENT_IN_N(oc_n),
    .ANALOG_OVERCURRENT(aoc), .PORT_POWER_ENABLE_N(pen_n));
  hrmoc_host HOST (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .dout(din), .din(dout), .oe(oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [18:0] a, input logic [31:0] d);
    HOST.xfer(a[17:1], d, 1'b1, rdat);
  endtask
  task automatic rd(input logic [18:0] a, input logic [31:0] e);
    HOST.xfer(a[17:1], 32'h0, 1'b0, rdat);
    chk(rdat, e);
  endtask
  task automatic pulse(input int c, input logic [31:0] b);
    @(posedge clk);
    done[c] <= b;
    @(posedge clk);
    done[c] <= '0;
    repeat (2) @(negedge clk);
  endtask
  // Far shorter than a real power-on reset, to keep runs brief
  task automatic reset_dut();
    rst_n <= 1'b0;
    req <= 3'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    reset_dut();
    chk({31'h0, int'(OC_FILTER_CYC) + 3 < OC_CUTOFF_MS * CLK_KHZ}, 32'h1);
    rd(19'h0, 32'h0100_0020);
    rd(19'h2, 32'h0100_0020);
    rd(19'h4, 32'h0000_0011);
    rd(19'h8, 32'h0000_0086);
    wr(19'h304, 32'h0);
    rd(19'h304, CHIP_ID_VAL);
    for (int i = 0; i < NRW; i++)
      rd({9'h0, RW_OFS[i]}, i == S_DMASTART ? 32'h0 : RW_RST[i]);
    for (int i = 0; i < NRW; i++) begin
      if (i == S_SWRST || i == S_DMASTART) continue;
      seed = xs(seed);
      wr({9'h0, RW_OFS[i]}, seed);
      rd({9'h0, RW_OFS[i]}, seed);
    end
    $display("registers done");
    wr(19'h308, 32'h5a5a_0ff0);
    rd(19'h30308, 32'h5a5a_0ff0);
    wr(19'h200, 32'h1234_5678);
    rd(19'h200, 32'h0);
    wr(19'h708, 32'h1);
    rd(19'h708, 32'h0);
    wr(19'h3f0, 32'h1);
    rd(19'h3f0, 32'h0);
    rd(19'h308, 32'h5a5a_0ff0);
    $display("decode done");
    reset_dut();
    wr(19'h314, 32'h0000_0380);
    wr(19'h31c, 32'h8);
    pulse(1, 32'h8);
    chk({31'h0, irq}, 32'h1);
    rd(19'h310, 32'h80);
    wr(19'h310, 32'h80);
    chk({31'h0, irq}, 32'h0);
    wr(19'h32c, 32'h16);
    pulse(2, 32'h6);
    chk({31'h0, irq}, 32'h0);
    pulse(2, 32'h10);
    chk({31'h0, irq}, 32'h1);
    rd(19'h310, 32'h100);
    wr(19'h318, 32'h1);
    pulse(0, 32'h1);
    rd(19'h310, 32'h300);
    rd(19'h150, 32'h16);
    rd(19'h130, 32'h1);
    rd(19'h130, 32'h0);
    $display("interrupts done");
    reset_dut();
    req <= 3'h7;
    oc_n <= 3'h6;
    repeat (20) @(posedge clk);
    chk({29'h0, pen_n}, 32'h0);
    aoc <= 3'h2;
    oc_n <= 3'h7;
    repeat (10) @(posedge clk);
    chk({29'h0, pen_n}, 32'h2);
    wr(19'h300, 32'h0000_8100);
    aoc <= 3'h4;
    oc_n <= 3'h6;
    repeat (6) @(posedge clk);
    oc_n <= 3'h7;
    repeat (20) @(posedge clk);
    chk({29'h0, pen_n}, 32'h2);
    oc_n <= 3'h6;
    repeat (FILT) @(posedge clk);
    chk({29'h0, pen_n}, 32'h2);
    repeat (8) @(posedge clk);
    chk({29'h0, pen_n}, 32'h3);
    oc_n <= 3'h7;
    aoc <= 3'h0;
    req <= 3'h0;
    repeat (20) @(posedge clk);
    req <= 3'h7;
    repeat (2) @(posedge clk);
    chk({29'h0, pen_n}, 32'h0);
    $display("power done");
    conclude();
  end
endmodule

// ==== hrmoc_host.sv ====
// Processor model for the parallel register bus.
// Assumes one access at a time, started by the bench.
`timescale 1ns/1ns
module hrmoc_host
  import hrmoc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Bus
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [17:1]      addr,
  output logic [31:0]      dout,
  input  wire logic [31:0] din,
  input  wire logic        oe
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 17'h0;
    dout = 32'h0;
  end
  // Strobes stay low past the synchroniser; released data is inverted
  task automatic xfer(input logic [17:1] a, input logic [31:0] d,
                      input logic wr, output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    dout <= d;
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    n = 0;
    // Answer is taken at the rising edge that also releases the strobes
    do begin
      @(posedge clk);
      n++;
    end while (wr ? n < 4 : (oe !== 1'b1 && n < 12));
    q = din;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    dout <= ~d;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ==== hrmoc_monitor.sv ====
// Checker of the bank's bus and port-power pins.
// Assumes it is bound onto hrmoc_top.
`timescale 1ns/1ns
module hrmoc_monitor
  import hrmoc_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // Bus
  input wire logic        CS_N,
  input wire logic        RD_N,
  input wire logic [17:1] ADDR,
  input wire logic [31:0] DATA_OUT,
  input wire logic        DATA_OE,
  // Port power
  input wire logic [2:0]  PORT_POWER_REQ,
  input wire logic [2:0]  PORT_OVERCURRENT_IN_N,
  input wire logic [2:0]  ANALOG_OVERCURRENT,
  input wire logic [2:0]  PORT_POWER_ENABLE_N
);
  logic [3:0] quiet_q;
  wire logic  cause = !PORT_OVERCURRENT_IN_N[0] || ANALOG_OVERCURRENT[0];
  wire logic  shut  = ADDR[9:8] == 2'h2 || |ADDR[15:10];
  // Cycles since port 0 saw a fault cause; a cut needs a recent cause
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) quiet_q <= 4'h0;
    else if (cause) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  pwr_off_a: assert property (
    &(PORT_POWER_ENABLE_N | $past(PORT_POWER_REQ))
  ) else $error("power on without request");
  pwr_on_a: assert property (
    $rose(PORT_POWER_REQ[0]) && quiet_q == 4'hf |=> !PORT_POWER_ENABLE_N[0]
  ) else $error("power not granted");
  cut_cause_a: assert property (
    $rose(PORT_POWER_ENABLE_N[0]) && $past(PORT_POWER_REQ[0]) |->
      quiet_q < 4'hf
  ) else $error("power cut without fault");
  rd_answer_a: assert property (
    $fell(RD_N) && !CS_N |-> ##[1:4] DATA_OE
  ) else $error("read not answered");
  oe_cause_a: assert property (
    $rose(DATA_OE) |-> $past(RD_N, 3) == 1'b0 && $past(CS_N, 3) == 1'b0
  ) else $error("bus driven without read");
  oe_drop_a: assert property (
    $rose(RD_N) |-> ##[1:4] !DATA_OE
  ) else $error("bus not released");
  idle_zero_a: assert property (
    !DATA_OE |-> DATA_OUT == 32'h0
  ) else $error("data while idle");
  refuse_zero_a: assert property (
    DATA_OE && $past(DATA_OE) && shut |-> DATA_OUT == 32'h0
  ) else $error("refused offset read nonzero");
endmodule
bind hrmoc_top hrmoc_monitor u_mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .CS_N(CS_N), .RD_N(RD_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE), .PORT_POWER_REQ(PORT_POWER_REQ),
  .PORT_OVERCURRENT_IN_N(PORT_OVERCURRENT_IN_N),
  .ANALOG_OVERCURRENT(ANALOG_OVERCURRENT),
  .PORT_POWER_ENABLE_N(PORT_POWER_ENABLE_N));

// ==== hrmoc_pkg.sv ====
// Constants, register map and carrier types of the host register bank
// with port-power overcurrent control.
// Assumes a single 25 MHz system clock and an asynchronous parallel bus.
package hrmoc_pkg;

  // Timing
  localparam int CLK_KHZ        = 25000;
  localparam int OC_FILTER_US   = 5000;
  localparam int OC_CUTOFF_MS   = 15;
  localparam logic [16:0] OC_FILTER_CYC =
    17'(OC_FILTER_US * CLK_KHZ / 1000);

  // Fixed capability words and decode
  localparam logic [9:0]  OFS_CAPLEN  = 10'h000;
  localparam logic [9:0]  OFS_VERSION = 10'h002;
  localparam logic [9:0]  OFS_STRUCT  = 10'h004;
  localparam logic [9:0]  OFS_CAPPAR  = 10'h008;
  localparam logic [9:0]  OFS_CHIPID  = 10'h304;
  localparam logic [9:0]  OFS_ISTAT   = 10'h310;
  localparam logic [7:0]  RST_CAPLEN  = 8'h20;
  localparam logic [15:0] RST_VERSION = 16'h0100;
  localparam logic [31:0] RST_STRUCT  = 32'h0000_0011;
  localparam logic [31:0] RST_CAPPAR  = 32'h0000_0086;
  // Arbitrary neutral identity value
  localparam logic [31:0] CHIP_ID_VAL = 32'h0000_a5a5;
  localparam logic [1:0]  REGION_PERIPH = 2'h2;

  // Descriptor classes and their done maps
  localparam int NCLS = 3;
  localparam logic [9:0] DONE_OFS [NCLS] = '{10'h130, 10'h140, 10'h150};
  localparam int ISTAT_BIT [NCLS] = '{9, 7, 8};

  // Plain read/write registers; the DMA start word reads back zero
  localparam int NRW = 29;
  typedef enum logic [4:0] {
    S_CMD, S_STS, S_INTSEL, S_FRIDX, S_CFGFLAG, S_PORTSC,
    S_ISO_SKIP, S_ISO_LAST, S_INT_SKIP, S_INT_LAST, S_ASY_SKIP, S_ASY_LAST,
    S_HWMODE, S_SCRATCH, S_SWRST, S_IEN,
    S_ISO_OR, S_INT_OR, S_ASY_OR, S_ISO_AND, S_INT_AND, S_ASY_AND,
    S_DMACFG, S_BUFST, S_ATLTO, S_MEMPTR, S_EDGE, S_DMASTART, S_PWRDN
  } hrmoc_slot_t;
  localparam logic [9:0] RW_OFS [NRW] = '{
    10'h020, 10'h024, 10'h028, 10'h02c, 10'h060, 10'h064,
    10'h134, 10'h138, 10'h144, 10'h148, 10'h154, 10'h158,
    10'h300, 10'h308, 10'h30c, 10'h314,
    10'h318, 10'h31c, 10'h320, 10'h324, 10'h328, 10'h32c,
    10'h330, 10'h334, 10'h338, 10'h33c, 10'h340, 10'h344, 10'h354};
  localparam logic [31:0] RW_RST [NRW] = '{
    32'h0008_0b00, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_2000,
    32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0,
    32'h0000_0100, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_000f, 32'h0, 32'h03e8_1ba0};
  localparam int HWMODE_OC_DIGITAL_BIT = 15;

  // Pins after synchronising; addr[0] is address line 1
  typedef struct packed {
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [16:0] addr;
    logic [31:0] data;
    logic [2:0]  oc_n;
    logic [2:0]  aoc;
  } hrmoc_pins_t;

  localparam hrmoc_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
    addr: 17'h0, data: 32'h0, oc_n: 3'h7, aoc: 3'h0};

endpackage

// ==== hrmoc_top.sv ====
// Host register bank of the controller with port-power overcurrent control.
// Assumes the processor bus strobes are asynchronous to CLK_SYS and that
// address and data are stable while a strobe is low.
`timescale 1ns/1ns
module hrmoc_top
  import hrmoc_pkg::*;
#(
  parameter logic [16:0] OC_FILTER_CYCLES = OC_FILTER_CYC
) (
  // Clock and reset
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESETN,
  // Processor bus
  input  wire logic                   CS_N,
  input  wire logic                   RD_N,
  input  wire logic                   WR_N,
  input  wire logic [17:1]            ADDR,
  input  wire logic [31:0]            DATA_IN,
  output logic      [31:0]            DATA_OUT,
  output logic                        DATA_OE,
  output logic                        IRQ_OUT,
  // Descriptor engine, same clock
  input  wire logic [NCLS-1:0][31:0]  DONE_SET,
  // Port power
  input  wire logic [2:0]             PORT_POWER_REQ,
  input  wire logic [2:0]             PORT_OVERCURRENT_IN_N,
  input  wire logic [2:0]             ANALOG_OVERCURRENT,
  output logic      [2:0]             PORT_POWER_ENABLE_N
);

  typedef struct packed {
    hrmoc_pins_t                s1;
    hrmoc_pins_t                s2;
    logic                       wr_prev;
    logic                       rd_prev;
    logic [16:0]                acc_addr;
    logic [31:0]                acc_data;
    logic [NRW-1:0][31:0]       rw;
    logic [NCLS-1:0][31:0]      done;
    logic [NCLS-1:0]            cond_prev;
    logic [31:0]                istat;
    logic                       irq;
    logic [31:0]                data_out;
    logic                       data_oe;
    logic [2:0][16:0]           oc_cnt;
    logic [2:0]                 fault;
    logic [2:0]                 pwr_n;
  } hrmoc_state_t;

  hrmoc_state_t st_q;
  hrmoc_state_t st_d;

  hrmoc_pins_t  pins_raw;

  assign pins_raw = '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, addr: ADDR,
    data: DATA_IN, oc_n: PORT_OVERCURRENT_IN_N, aoc: ANALOG_OVERCURRENT};

  // Bank bits are ignored here: registers appear in every bank.
  function automatic logic in_reg_space(input logic [16:0] a);
    return a[14:9] == 6'h00;
  endfunction

  // Dword offset: line 1 does not select a half on the 32-bit bus.
  function automatic logic [9:0] word_ofs(input logic [16:0] a);
    return {a[8:1], 2'b00};
  endfunction

  function automatic logic [31:0] read_word(input hrmoc_state_t s,
                                            input logic [16:0]  a);
    logic [9:0]  ofs;
    logic [31:0] val;
    ofs = word_ofs(a);
    val = 32'h0;
    if (in_reg_space(a) && ofs[9:8] != REGION_PERIPH) begin
      if (ofs == OFS_CAPLEN) begin
        val = {RST_VERSION, 8'h00, RST_CAPLEN};
      end else if (ofs == OFS_STRUCT) begin
        val = RST_STRUCT;
      end else if (ofs == OFS_CAPPAR) begin
        val = RST_CAPPAR;
      end else if (ofs == OFS_CHIPID) begin
        val = CHIP_ID_VAL;
      end else if (ofs == OFS_ISTAT) begin
        val = s.istat;
      end
      for (int c = 0; c < NCLS; c++) begin
        if (ofs == DONE_OFS[c]) begin
          val = s.done[c];
        end
      end
      for (int i = 0; i < NRW; i++) begin
        // The DMA start word is write only and reads zero
        if (ofs == RW_OFS[i] && i != int'(S_DMASTART)) begin
          val = s.rw[i];
        end
      end
    end
    return val;
  endfunction

  always_comb begin
    logic        wr_end;
    logic        rd_end;
    logic        access;
    logic [9:0]  ofs;
    logic        hit_ok;
    logic [31:0] orm;
    logic [31:0] andm;
    logic [NCLS-1:0] cond;
    logic        digital;
    logic        oc_now;

    st_d    = st_q;
    wr_end  = 1'b0;
    rd_end  = 1'b0;
    access  = 1'b0;
    ofs     = 10'h0;
    hit_ok  = 1'b0;
    orm     = 32'h0;
    andm    = 32'h0;
    cond    = '0;
    digital = 1'b0;
    oc_now  = 1'b0;

    // Two-stage synchronisers; only s2 is read below
    st_d.s1 = pins_raw;
    st_d.s2 = st_q.s1;
    st_d.wr_prev = st_q.s2.wr_n;
    st_d.rd_prev = st_q.s2.rd_n;

    // Address and data are captured while a strobe is low so the commit at
    // the strobe's rising edge does not depend on bus hold time.
    access = !st_q.s2.cs_n && (!st_q.s2.rd_n || !st_q.s2.wr_n);
    if (access) begin
      st_d.acc_addr = st_q.s2.addr;
      st_d.acc_data = st_q.s2.data;
    end
    wr_end = !st_q.wr_prev && st_q.s2.wr_n;
    rd_end = !st_q.rd_prev && st_q.s2.rd_n;

    // Read data is driven while chip select and read are both low
    if (!st_q.s2.cs_n && !st_q.s2.rd_n) begin
      st_d.data_out = read_word(st_q, st_q.s2.addr);
      st_d.data_oe  = 1'b1;
    end else begin
      st_d.data_out = 32'h0;
      st_d.data_oe  = 1'b0;
    end

    ofs    = word_ofs(st_q.acc_addr);
    hit_ok = in_reg_space(st_q.acc_addr) && ofs[9:8] != REGION_PERIPH;

    // Register writes; offsets with no register fall through untouched
    if (wr_end && hit_ok) begin
      for (int i = 0; i < NRW; i++) begin
        if (ofs == RW_OFS[i]) begin
          st_d.rw[i] = st_q.acc_data;
        end
      end
      if (ofs == OFS_ISTAT) begin
        st_d.istat = st_q.istat & ~st_q.acc_data;
      end
    end

    // Done maps clear when read; a completion in the same cycle survives
    for (int c = 0; c < NCLS; c++) begin
      if (rd_end && hit_ok && ofs == DONE_OFS[c]) begin
        st_d.done[c] = 32'h0;
      end
      st_d.done[c] = st_d.done[c] | DONE_SET[c];
    end

    // Descriptor interrupt per class, evaluated on the updated done map
    for (int c = 0; c < NCLS; c++) begin
      orm  = st_q.rw[int'(S_ISO_OR) + c];
      andm = st_q.rw[int'(S_ISO_AND) + c] & ~orm;
      cond[c] = |(st_d.done[c] & orm);
      if (andm != 32'h0 && (st_d.done[c] & andm) == andm) begin
        cond[c] = 1'b1;
      end
      st_d.cond_prev[c] = cond[c];
      // Set beats a simultaneous write-one-to-clear
      if (cond[c] && !st_q.cond_prev[c]) begin
        st_d.istat[ISTAT_BIT[c]] = 1'b1;
      end
    end
    st_d.irq = |(st_d.istat & st_q.rw[S_IEN]);

    // Port power and overcurrent, one shared mode bit for all ports
    digital = st_q.rw[S_HWMODE][HWMODE_OC_DIGITAL_BIT];
    for (int p = 0; p < 3; p++) begin
      oc_now = 1'b0;
      if (digital) begin
        // Inrush filter: the input must stay low for the whole window.
        if (!st_q.s2.oc_n[p]) begin
          if (st_q.oc_cnt[p] < OC_FILTER_CYCLES) begin
            st_d.oc_cnt[p] = st_q.oc_cnt[p] + 17'h1;
          end else begin
            oc_now = 1'b1;
          end
        end else begin
          st_d.oc_cnt[p] = 17'h0;
        end
      end else begin
        // The on-chip detector does its own deglitching
        st_d.oc_cnt[p] = 17'h0;
        oc_now = st_q.s2.aoc[p];
      end
      // Fault holds power off until the port's power request is dropped
      if (oc_now) begin
        st_d.fault[p] = 1'b1;
      end else if (!PORT_POWER_REQ[p]) begin
        st_d.fault[p] = 1'b0;
      end
      st_d.pwr_n[p] = !(PORT_POWER_REQ[p] && !st_d.fault[p]);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st_q           <= '0;
      st_q.s1        <= PINS_IDLE;
      st_q.s2        <= PINS_IDLE;
      st_q.wr_prev   <= 1'b1;
      st_q.rd_prev   <= 1'b1;
      st_q.pwr_n     <= 3'h7;
      for (int i = 0; i < NRW; i++) begin
        st_q.rw[i] <= RW_RST[i];
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign DATA_OUT            = st_q.data_out;
  assign DATA_OE             = st_q.data_oe;
  assign IRQ_OUT             = st_q.irq;
  assign PORT_POWER_ENABLE_N = st_q.pwr_n;

endmodule
